// file: swr_cfg.svh
// constants for the sleep/wake and reset-cause block
`ifndef SWR_CFG_SVH
`define SWR_CFG_SVH
// register byte addresses (low address bits)
`define SWR_ADDR_RCS 8'h00
`define SWR_ADDR_PWR 8'h04
`define SWR_ADDR_LSB 8'h03
// reset control status field positions
`define SWR_BIT_PRIO_EN 7
`define SWR_BIT_SWBRN_EN 6
`define SWR_BIT_RSTI 4
`define SWR_BIT_TO 3
`define SWR_BIT_PDOWN 2
`define SWR_BIT_POR 1
`define SWR_BIT_BOR 0
// value after power-on, and bits software may write
`define SWR_RCS_POR_VAL 8'h1c
`define SWR_RCS_WR_MASK 8'hd3
// brownout config value that hands control to software
`define SWR_BOR_SW_CFG 2'h1
// wake settling time and the clock rate
`define SWR_SETTLE_NS 200
`define SWR_CLK_MHZ 25
`define SWR_SETTLE_CYC ((`SWR_SETTLE_NS * `SWR_CLK_MHZ + 999) / 1000)
// bus answers
`define SWR_HTRANS_NONSEQ 2'h2
`define SWR_HRESP_OKAY 1'h0
`define SWR_ZERO32 32'h0000_0000
`endif

// file: swr_pkg.sv
// types for the sleep/wake and reset-cause block
`default_nettype none
package swr_pkg;
  // power-management state
  typedef enum logic [1:0] {
    SWR_RUN    = 2'b00,
    SWR_SLEEP  = 2'b01,
    SWR_OSCWAIT = 2'b10,
    SWR_SETTLE = 2'b11
  } swr_state_t;
  // what ended the last power-managed period
  typedef enum logic [1:0] {
    SWR_WK_NONE  = 2'b00,
    SWR_WK_IRQ   = 2'b01,
    SWR_WK_WDT   = 2'b10,
    SWR_WK_RESET = 2'b11
  } swr_wake_t;
  // main oscillator mode
  typedef enum logic [2:0] {
    SWR_OSC_XLP   = 3'b000,
    SWR_OSC_XTAL  = 3'b001,
    SWR_OSC_XFAST = 3'b010,
    SWR_OSC_XMUL  = 3'b011,
    SWR_OSC_RC    = 3'b100,
    SWR_OSC_EC    = 3'b101,
    SWR_OSC_INT   = 3'b110,
    SWR_OSC_INTIO = 3'b111
  } swr_osc_t;
  // one-cycle events from the core and reset logic
  typedef struct packed {
    logic sleep_exec;
    logic idle_sel;
    logic main_clock_idle_mode;
    logic watchdog_clear_instr;
    logic reset_instr;
    logic ext_reset;
    logic bor_event;
    logic wdt_timeout;
  } swr_core_ev_t;
  // clock-system conditions
  typedef struct packed {
    swr_osc_t osc_mode;
    logic clock_fail;
    logic fail_safe_enable;
    logic intosc_is_sysclk;
    logic internal_osc_freq_select_wr;
    logic osc_startup_done;
  } swr_clk_t;
  // wake outcome towards the core
  typedef struct packed {
    logic fetch_stall;
    logic resume;
    logic take_vector;
    logic restart_zero;
    logic wdt_reset;
    logic wdt_clear;
    logic osc_startup_req;
  } swr_core_out_t;
endpackage : swr_pkg
`default_nettype wire

// file: swr_settle.sv
// down-counter that times the wake settling interval
`default_nettype none
`include "swr_cfg.svh"
module swr_settle #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic start,
  input wire logic [W-1:0] load_val,
  // status
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // load on start, then count down to zero
  always_comb begin
    nxt_cnt = cnt_ff;
    if (start) begin
      nxt_cnt = load_val;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = (cnt_ff == W'(1)) && !start; // last cycle of the interval
endmodule // swr_settle
`default_nettype wire

// file: swr_core.sv
// sleep/idle exit control, watchdog clearing and reset-cause status register
//
// Chosen here: the AHB-Lite register port and the address map.
`default_nettype none
`include "swr_cfg.svh"
module swr_core
  import swr_pkg::*;
#(
  parameter int unsigned N_IRQ = 8,
  parameter int unsigned SETTLE_CYC = `SWR_SETTLE_CYC,
  parameter int unsigned CW = 8
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // core and reset events
  input wire swr_pkg::swr_core_ev_t core_ev,
  input wire logic [N_IRQ-1:0] irq_pending,
  input wire logic [N_IRQ-1:0] irq_enable,
  input wire logic global_irq_enable,
  // clock system and configuration
  input wire swr_pkg::swr_clk_t clk_sys,
  input wire logic [1:0] brownout_config_field,
  // outputs to core and clock system
  output swr_pkg::swr_core_out_t core_out,
  output logic sw_brownout_enable,
  output logic irq_priority_enable
);
  import swr_pkg::*;

  // bus address-phase capture
  logic wr_pend_ff;
  logic nxt_wr_pend;
  logic [7:0] wr_addr_ff;
  logic [7:0] nxt_wr_addr;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic ap_valid;

  // register and sequence state
  logic [7:0] rcs_ff;
  logic [7:0] nxt_rcs;
  logic init_ff;
  logic nxt_init;
  swr_state_t state_ff;
  swr_state_t nxt_state;
  swr_wake_t wake_ff;
  swr_wake_t nxt_wake;
  logic idle_ff;
  logic nxt_idle;
  logic main_clock_idle_mode_ff;
  logic nxt_main_clock_idle_mode;
  swr_core_out_t out_ff;
  swr_core_out_t nxt_out;

  // settle counter hookup
  logic settle_start;
  logic settle_busy;
  logic settle_done;

  // helpers
  logic irq_wake;
  logic any_reset;
  logic crystal_mode;
  logic [7:0] pwr_status;

  swr_settle #(
    .W(CW)
  ) u_settle (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(settle_start),
    .load_val(CW'(SETTLE_CYC)),
    .busy(settle_busy),
    .done(settle_done)
  );

  // wake and reset conditions
  assign irq_wake = |(irq_pending & irq_enable);
  assign any_reset = core_ev.reset_instr | core_ev.ext_reset | core_ev.bor_event;
  assign crystal_mode = (clk_sys.osc_mode == SWR_OSC_XLP) || (clk_sys.osc_mode == SWR_OSC_XTAL) ||
                        (clk_sys.osc_mode == SWR_OSC_XFAST) || (clk_sys.osc_mode == SWR_OSC_XMUL);
  assign ap_valid = hsel && hready && (htrans == `SWR_HTRANS_NONSEQ);
  assign pwr_status = {idle_ff, settle_busy, out_ff.take_vector, wake_ff, main_clock_idle_mode_ff, state_ff};

  // bus: zero wait states, read data fetched in the address phase
  always_comb begin
    nxt_wr_pend = ap_valid && hwrite;
    nxt_wr_addr = wr_addr_ff;
    nxt_rdata = rdata_ff;
    if (ap_valid) begin
      nxt_wr_addr = haddr[7:0] & ~`SWR_ADDR_LSB;
      nxt_rdata = `SWR_ZERO32;
      if (!hwrite) begin
        case (haddr[7:0] & ~`SWR_ADDR_LSB)
          `SWR_ADDR_RCS: nxt_rdata = {24'h00_0000, rcs_ff};
          `SWR_ADDR_PWR: nxt_rdata = {24'h00_0000, pwr_status};
          default: nxt_rdata = `SWR_ZERO32;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= `SWR_ZERO32;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff <= nxt_rdata;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = `SWR_HRESP_OKAY;
  assign hrdata = rdata_ff;

  // reset control status: software write first, hardware events override it
  always_comb begin
    nxt_rcs = rcs_ff;
    nxt_init = 1'b0;
    if (wr_pend_ff && (wr_addr_ff == `SWR_ADDR_RCS)) begin
      nxt_rcs = (rcs_ff & ~`SWR_RCS_WR_MASK) | (hwdata[7:0] & `SWR_RCS_WR_MASK);
    end
    if (init_ff) begin
      nxt_rcs[`SWR_BIT_SWBRN_EN] = (brownout_config_field == `SWR_BOR_SW_CFG);
    end
    if (core_ev.sleep_exec) begin
      nxt_rcs[`SWR_BIT_TO] = 1'b1;
      nxt_rcs[`SWR_BIT_PDOWN] = 1'b0;
    end
    if (core_ev.watchdog_clear_instr) begin
      nxt_rcs[`SWR_BIT_TO] = 1'b1;
      nxt_rcs[`SWR_BIT_PDOWN] = 1'b1;
    end
    if (core_ev.wdt_timeout) begin
      nxt_rcs[`SWR_BIT_TO] = 1'b0;
    end
    if (core_ev.reset_instr) begin
      nxt_rcs[`SWR_BIT_RSTI] = 1'b0;
    end
    if (core_ev.bor_event) begin
      nxt_rcs[`SWR_BIT_BOR] = 1'b0;
    end
    if (any_reset || (core_ev.wdt_timeout && (state_ff == SWR_RUN))) begin
      nxt_rcs[`SWR_BIT_PRIO_EN] = 1'b0;
    end
  end

  // init flag marks the first cycle after power-on release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rcs_ff <= `SWR_RCS_POR_VAL;
      init_ff <= 1'b1;
    end else begin
      rcs_ff <= nxt_rcs;
      init_ff <= nxt_init;
    end
  end

  assign sw_brownout_enable = rcs_ff[`SWR_BIT_SWBRN_EN];
  assign irq_priority_enable = rcs_ff[`SWR_BIT_PRIO_EN];

  // power-managed sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_wake = wake_ff;
    nxt_idle = idle_ff;
    nxt_main_clock_idle_mode = main_clock_idle_mode_ff;
    nxt_out = '0;
    nxt_out.take_vector = out_ff.take_vector;
    settle_start = 1'b0;
    // watchdog clear sources
    nxt_out.wdt_clear = core_ev.sleep_exec | core_ev.watchdog_clear_instr;
    if ((clk_sys.clock_fail && clk_sys.fail_safe_enable) ||
        (clk_sys.internal_osc_freq_select_wr && clk_sys.intosc_is_sysclk)) begin
      nxt_out.wdt_clear = 1'b1;
    end
    if (any_reset) begin
      nxt_state = SWR_RUN;
      nxt_out.restart_zero = 1'b1;
      nxt_out.take_vector = 1'b0;
      if (state_ff != SWR_RUN) begin
        nxt_wake = SWR_WK_RESET;
      end
    end else begin
      case (state_ff)
        SWR_RUN: begin
          if (core_ev.wdt_timeout) begin
            nxt_out.wdt_reset = 1'b1;
            nxt_out.restart_zero = 1'b1;
            nxt_out.take_vector = 1'b0;
          end else if (core_ev.sleep_exec) begin
            nxt_state = SWR_SLEEP;
            nxt_idle = core_ev.idle_sel;
            nxt_main_clock_idle_mode = core_ev.idle_sel && core_ev.main_clock_idle_mode;
            nxt_out.take_vector = 1'b0;
          end
        end
        SWR_SLEEP: begin
          if (irq_wake || core_ev.wdt_timeout) begin
            nxt_wake = irq_wake ? SWR_WK_IRQ : SWR_WK_WDT;
            if (!main_clock_idle_mode_ff && crystal_mode) begin
              nxt_state = SWR_OSCWAIT;
            end else begin
              nxt_state = SWR_SETTLE;
              settle_start = 1'b1;
            end
          end
        end
        SWR_OSCWAIT: begin
          nxt_out.osc_startup_req = !clk_sys.osc_startup_done;
          if (clk_sys.osc_startup_done) begin
            nxt_state = SWR_SETTLE;
            settle_start = 1'b1;
          end
        end
        SWR_SETTLE: begin
          if (settle_done) begin
            nxt_state = SWR_RUN;
            nxt_out.resume = 1'b1;
            nxt_out.take_vector = (wake_ff == SWR_WK_IRQ) && global_irq_enable;
          end
        end
        default: begin
          nxt_state = SWR_RUN;
        end
      endcase
    end
    // fetch is held off until the settle interval is over
    nxt_out.fetch_stall = (nxt_state != SWR_RUN);
    if (nxt_state == SWR_OSCWAIT) begin
      nxt_out.osc_startup_req = !clk_sys.osc_startup_done;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= SWR_RUN;
      wake_ff <= SWR_WK_NONE;
      idle_ff <= 1'b0;
      main_clock_idle_mode_ff <= 1'b0;
      out_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      wake_ff <= nxt_wake;
      idle_ff <= nxt_idle;
      main_clock_idle_mode_ff <= nxt_main_clock_idle_mode;
      out_ff <= nxt_out;
    end
  end

  assign core_out = out_ff;
endmodule // swr_core
`default_nettype wire

// file: swr_core_sva.sv
// assertions on the ports of the sleep/wake core
`default_nettype none
module swr_core_sva
  import swr_pkg::*;
#(
  parameter int unsigned N_IRQ = 8,
  parameter int unsigned SETTLE_CYC = 5
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // core and clock side
  input wire swr_pkg::swr_core_ev_t core_ev,
  input wire logic [N_IRQ-1:0] irq_pending,
  input wire logic [N_IRQ-1:0] irq_enable,
  input wire logic global_irq_enable,
  input wire swr_pkg::swr_clk_t clk_sys,
  input wire swr_pkg::swr_core_out_t core_out
);
  localparam int SW = SETTLE_CYC + 1;
  logic irq_w;
  logic rst_w;
  logic asleep_ff, nxt_asleep, skip_ff, nxt_skip, irqw_ff, nxt_irqw;
  assign irq_w = |(irq_pending & irq_enable);
  assign rst_w = core_ev.reset_instr | core_ev.ext_reset | core_ev.bor_event;
  // shadow of the sleeping state, whether start-up is skipped, what woke it
  always_comb begin
    nxt_asleep = asleep_ff;
    nxt_skip = skip_ff;
    nxt_irqw = irqw_ff;
    if (core_ev.sleep_exec && !core_out.fetch_stall && !core_ev.wdt_timeout) begin
      nxt_asleep = 1'b1;
      nxt_skip = (core_ev.idle_sel & core_ev.main_clock_idle_mode) | clk_sys.osc_mode[2];
      nxt_irqw = 1'b0;
    end else if (asleep_ff && (irq_w || core_ev.wdt_timeout)) begin
      nxt_asleep = 1'b0;
      nxt_irqw = irq_w;
    end
    if (rst_w) nxt_asleep = 1'b0;
  end
  // shadow registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      asleep_ff <= 1'b0;
      skip_ff <= 1'b0;
      irqw_ff <= 1'b0;
    end else begin
      asleep_ff <= nxt_asleep;
      skip_ff <= nxt_skip;
      irqw_ff <= nxt_irqw;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // the steps of a sleep period
  sequence s_entry;
    core_ev.sleep_exec && !core_out.fetch_stall && !rst_w && !core_ev.wdt_timeout;
  endsequence
  sequence s_fast_wake;
    asleep_ff && skip_ff && irq_w && !rst_w;
  endsequence
  sequence s_slow_wake;
    asleep_ff && !skip_ff && irq_w && !rst_w;
  endsequence
  a_sleep_clears_wdt: assert property (s_entry |=> core_out.wdt_clear && core_out.fetch_stall)
    else $error("sleep entry did not clear watchdog");
  a_clock_clears_wdt: assert property ((clk_sys.clock_fail && clk_sys.fail_safe_enable) ||
    (clk_sys.internal_osc_freq_select_wr && clk_sys.intosc_is_sysclk) |=> core_out.wdt_clear)
    else $error("clock event did not clear watchdog");
  a_run_wdt_reset: assert property (core_ev.wdt_timeout && !core_out.fetch_stall && !core_ev.sleep_exec
    && !rst_w |=> core_out.wdt_reset) else $error("timeout in run gave no reset");
  a_sleep_wdt_wakes: assert property (asleep_ff && core_ev.wdt_timeout && !rst_w
    |=> !core_out.wdt_reset && core_out.fetch_stall) else $error("timeout in sleep reset the part");
  a_settle_time: assert property (s_fast_wake |-> ##SW core_out.resume ##0 !core_out.fetch_stall)
    else $error("resume not at end of settle interval");
  a_vector_choice: assert property (core_out.resume && irqw_ff
    |-> core_out.take_vector == $past(global_irq_enable)) else $error("vector choice wrong");
  a_ost_wait: assert property (s_slow_wake |=> core_out.osc_startup_req && core_out.fetch_stall)
    else $error("crystal wake skipped start-up");
  a_reset_exit: assert property (asleep_ff && core_ev.ext_reset
    |=> core_out.restart_zero && !core_out.fetch_stall) else $error("reset did not restart at zero");
  a_stay_asleep: assert property (asleep_ff && !irq_w && !core_ev.wdt_timeout && !rst_w
    |=> core_out.fetch_stall && !core_out.resume) else $error("woke without a cause");
endmodule // swr_core_sva
bind swr_core swr_core_sva #(.N_IRQ(N_IRQ), .SETTLE_CYC(SETTLE_CYC)) i_sva (.hclk(hclk), .hresetn(hresetn),
  .core_ev(core_ev), .irq_pending(irq_pending), .irq_enable(irq_enable), .global_irq_enable(global_irq_enable),
  .clk_sys(clk_sys), .core_out(core_out));
`default_nettype wire

// file: test_sleep_wake_and_reset_cause.sv
// self-checking bench for the sleep/wake and reset-cause core
`default_nettype none
`include "swr_cfg.svh"
module test_sleep_wake_and_reset_cause;
  import swr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned ST = 3;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = `SWR_ZERO32;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = `SWR_ZERO32;
  logic hready, hreadyout, hresp, sbe, ipe;
  logic [31:0] hrdata, rd;
  swr_core_ev_t ev = '0;
  logic [7:0] pend = 8'h00;
  logic [7:0] en = 8'h00;
  logic gie = 1'b0;
  swr_clk_t cs = {SWR_OSC_RC, 5'h00};
  logic [1:0] bcfg = `SWR_BOR_SW_CFG;
  swr_core_out_t co;
  int err_total = 0;
  int compares = 0;
  assign hready = hreadyout;
  // 25 MHz clock
  always #20 hclk = ~hclk;
  swr_core #(.SETTLE_CYC(ST)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .core_ev(ev), .irq_pending(pend), .irq_enable(en),
    .global_irq_enable(gie), .clk_sys(cs), .brownout_config_field(bcfg), .core_out(co),
    .sw_brownout_enable(sbe), .irq_priority_enable(ipe));
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= `SWR_HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // one-cycle core event, outputs settled after its edge
  task automatic pulse(input swr_core_ev_t e);
    @(posedge hclk);
    ev <= e;
    @(posedge hclk);
    ev <= '0;
    #1;
  endtask
  // count edges until resume shows
  task automatic wait_resume(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (co.resume !== 1'b1 && n < 40);
  endtask
  // clock-system event and whether it clears the watchdog
  task automatic clk_ev(input logic [4:0] b, input logic exp);
    @(posedge hclk);
    cs[4:0] <= b;
    @(posedge hclk);
    cs[4:0] <= 5'h00;
    #1;
    chk("clock clear", 32'(co.wdt_clear), 32'(exp));
  endtask
  // reset values, write mask, unmapped place, brownout flags
  task automatic t_regs;
    chk("sbor out", 32'(sbe), 32'h0000_0001);
    bus(1'b0, 32'h0000_0000, `SWR_ZERO32);
    chk("rcs reset", rd, 32'h0000_005c);
    bus(1'b1, 32'h0000_0000, 32'h0000_00ff);
    bus(1'b0, 32'h0000_0000, `SWR_ZERO32);
    chk("rcs written", rd, 32'h0000_00df);
    chk("irq_priority_enable out", 32'(ipe), 32'h0000_0001);
    bus(1'b0, 32'h0000_0010, `SWR_ZERO32);
    chk("unmapped", rd, `SWR_ZERO32);
    pulse(8'h02);
    bus(1'b0, 32'h0000_0000, `SWR_ZERO32);
    chk("bor flags", 32'(rd[1:0]), 32'h0000_0002);
    chk("irq_priority_enable cleared", 32'(ipe), `SWR_ZERO32);
  endtask
  // interrupt wake with a given global enable
  task automatic t_irq(input logic g);
    int n;
    gie <= g;
    pulse(8'h80);
    chk("sleep clear", 32'({co.wdt_clear, co.fetch_stall}), 32'h0000_0003);
    pend <= 8'h01;
    repeat (4) @(posedge hclk);
    #1;
    chk("masked irq", 32'(co.fetch_stall), 32'h0000_0001);
    @(posedge hclk);
    en <= 8'h01;
    wait_resume(n);
    chk("settle cycles", 32'(n), 32'(ST + 1));
    chk("vector", 32'(co.take_vector), 32'(g));
    @(posedge hclk);
    pend <= 8'h00;
    en <= 8'h00;
    bus(1'b0, 32'h0000_0004, `SWR_ZERO32);
    chk("wake cause", 32'(rd[4:3]), 32'h0000_0001);
  endtask
  // watchdog timeout asleep, then running
  task automatic t_wdt;
    int n;
    pulse(8'h80);
    pulse(8'h01);
    chk("no wdt reset", 32'(co.wdt_reset), `SWR_ZERO32);
    wait_resume(n);
    chk("wdt wake", 32'(n), 32'(ST));
    pulse(8'h01);
    chk("run wdt reset", 32'(co.wdt_reset), 32'h0000_0001);
  endtask
  // crystal mode waits for start-up timer
  task automatic t_ost;
    int n;
    cs.osc_mode <= SWR_OSC_XTAL;
    pulse(8'h80);
    pend <= 8'h01;
    en <= 8'h01;
    repeat (2) @(posedge hclk);
    #1;
    chk("ost wait", 32'({co.osc_startup_req, co.fetch_stall}), 32'h0000_0003);
    cs.osc_startup_done <= 1'b1;
    wait_resume(n);
    chk("ost resume", 32'(co.resume), 32'h0000_0001);
    cs <= {SWR_OSC_RC, 5'h00};
    pend <= 8'h00;
    en <= 8'h00;
  endtask
  // reset ends sleep, then the watchdog clearing events
  task automatic t_rst;
    pulse(8'h80);
    pulse(8'h04);
    chk("restart", 32'({co.restart_zero, co.fetch_stall}), 32'h0000_0002);
    pulse(8'h10);
    chk("watchdog_clear_instr", 32'(co.wdt_clear), 32'h0000_0001);
    clk_ev(5'h18, 1'b1);
    clk_ev(5'h10, 1'b0);
    clk_ev(5'h06, 1'b1);
    clk_ev(5'h02, 1'b0);
  endtask
  // print counts and verdict, end the run
  task automatic give_verdict;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    t_regs();
    t_irq(1'b0);
    t_irq(1'b1);
    t_wdt();
    t_ost();
    t_rst();
    give_verdict();
  end
  // hang guard
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule // test_sleep_wake_and_reset_cause
`default_nettype wire
